// file: verilog/vdrp_ctrl.sv
`timescale 1ns/1ps
module vdrp_ctrl
  import vdrp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire vdrp_req_s req,
  // Read answer
  output logic rsp_valid,
  output logic [DQ_W-1:0] rsp_data,
  // Status
  output logic refresh_pending,
  // Memory pins
  output vdrp_pins_s pins,
  input wire logic [DQ_W-1:0] mask_or_data_pins_in
);

  vdrp_state_e state;
  vdrp_state_e next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [TMR_W-1:0] ras_age;
  logic [TMR_W-1:0] next_ras_age;
  vdrp_req_s cur;
  vdrp_req_s next_cur;
  vdrp_pins_s next_pins;
  logic next_rsp_valid;
  logic [DQ_W-1:0] next_rsp_data;
  logic ref_due;
  logic ref_ack;
  logic accept;
  logic page_hit;
  logic ras_ok;
  logic masked;

  vdrp_refresh_timer u_refresh (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .ack(ref_ack),
    .due(ref_due)
  );

  assign refresh_pending = ref_due;

  // Pin levels for a column strobe fall
  function automatic vdrp_pins_s col_pins(vdrp_pins_s p, vdrp_req_s r);
    vdrp_pins_s q;
    q = p;
    q.cas_n = 1'h0;
    q.addr = r.col;
    q.special_function_select = 1'h0;
    q.transfer_or_output_enable_n = 1'h1;
    q.mask_select_write_enable_n = 1'h1;
    q.mask_or_data_pins_out = r.wdata;
    q.mask_or_data_pins_oe = 1'h0;
    case (r.op)
      OP_READ: begin
        q.transfer_or_output_enable_n = 1'h0;
      end
      OP_WRITE: begin
        // Early write: enable low with the strobe, so the device stays off
        q.mask_select_write_enable_n = 1'h0;
        q.mask_or_data_pins_oe = 1'h1;
      end
      OP_BLOCK: begin
        q.special_function_select = 1'h1;
        q.addr[BLOCK_COL_LSB-1:0] = '0;
        q.mask_select_write_enable_n = 1'h0;
        q.mask_or_data_pins_oe = 1'h1;
      end
      default: begin
      end
    endcase
    return q;
  endfunction

  always_comb begin
    // Page hits only for plain accesses; a latched mask must not outlive its cycle
    page_hit = (req.row == cur.row) && cur.keep_page && !cur.use_mask && !req.use_mask
      && ((req.op == OP_READ) || (req.op == OP_WRITE));
    req_ready = ce && !ref_due
      && ((state == ST_IDLE) || ((state == ST_PAGE) && (tmr == '0) && page_hit));
    accept = req_valid && req_ready;
    ras_ok = (ras_age >= TMR_RAS);
    masked = (req.op == OP_FLASH)
      || (req.use_mask && ((req.op == OP_WRITE) || (req.op == OP_BLOCK)));
  end

  always_comb begin
    next_state = state;
    next_tmr = (tmr != '0) ? tmr - 1'h1 : tmr;
    next_ras_age = pins.ras_n ? '0 : ((ras_age != TMR_MAX) ? ras_age + 1'h1 : ras_age);
    next_cur = cur;
    next_pins = pins;
    next_rsp_valid = 1'h0;
    next_rsp_data = rsp_data;
    ref_ack = 1'h0;
    case (state)
      ST_IDLE: begin
        if (ref_due || (accept && (req.op == OP_REF_CBR))) begin
          // Column strobe first, so the device supplies the refresh row
          next_pins.cas_n = 1'h0;
          ref_ack = ref_due;
          next_cur = req;
          next_state = ST_CBR_CAS;
          next_tmr = TMR_CSR;
        end else if (accept) begin
          next_cur = req;
          next_pins.ras_n = 1'h0;
          next_pins.cas_n = 1'h1;
          next_pins.addr = req.row;
          // Output-enable high here, or the fall would start a transfer
          next_pins.transfer_or_output_enable_n = 1'h1;
          next_pins.mask_select_write_enable_n = !masked;
          next_pins.special_function_select = (req.op == OP_FLASH);
          next_pins.mask_or_data_pins_out = req.mask;
          next_pins.mask_or_data_pins_oe = masked;
          next_state = ST_ROW;
          next_tmr = TMR_RCD;
        end
      end
      ST_ROW: begin
        if (tmr == '0) begin
          if ((cur.op == OP_FLASH) || (cur.op == OP_REF_ROW)) begin
            // Column strobe never falls in these cycles
            if (ras_ok) begin
              next_pins = PINS_IDLE;
              next_state = ST_PRE;
              next_tmr = TMR_RP;
            end
          end else begin
            next_pins = col_pins(pins, cur);
            next_state = ST_COL;
            next_tmr = TMR_COL;
          end
        end
      end
      ST_COL: begin
        // A read that turns into a hidden refresh first waits out the row strobe minimum
        if ((tmr == '0) && !((cur.op == OP_READ) && ref_due && !ras_ok)) begin
          if (cur.op == OP_READ) begin
            next_rsp_valid = 1'h1;
            next_rsp_data = mask_or_data_pins_in;
          end
          if ((cur.op == OP_READ) && ref_due) begin
            // Column strobe and output-enable stay low; data is held on the pins
            next_pins.ras_n = 1'h1;
            ref_ack = 1'h1;
            next_state = ST_HIDDEN;
            next_tmr = TMR_RP;
          end else begin
            next_pins.cas_n = 1'h1;
            next_pins.transfer_or_output_enable_n = 1'h1;
            next_pins.mask_select_write_enable_n = 1'h1;
            next_pins.special_function_select = 1'h0;
            next_pins.mask_or_data_pins_oe = 1'h0;
            next_state = ST_PAGE;
            next_tmr = TMR_CP;
          end
        end
      end
      ST_PAGE: begin
        if (accept) begin
          next_cur = req;
          next_pins = col_pins(pins, req);
          next_state = ST_COL;
          next_tmr = TMR_COL;
        end else if (ras_ok && (tmr == '0)
            && (!cur.keep_page || ref_due || req_valid)) begin
          next_pins = PINS_IDLE;
          next_state = ST_PRE;
          next_tmr = TMR_RP;
        end
      end
      ST_HIDDEN: begin
        if (tmr == '0) begin
          next_pins.ras_n = 1'h0;
          next_state = ST_CBR_RAS;
        end
      end
      ST_CBR_CAS: begin
        if (tmr == '0) begin
          next_pins.ras_n = 1'h0;
          next_state = ST_CBR_RAS;
        end
      end
      ST_CBR_RAS: begin
        if (ras_ok) begin
          next_pins = PINS_IDLE;
          next_state = ST_PRE;
          next_tmr = TMR_RP;
        end
      end
      ST_PRE: begin
        // Leaving here costs one more high cycle in idle before the next fall
        if (tmr == '0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_pins = PINS_IDLE;
        next_state = ST_IDLE;
        next_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
      tmr <= '0;
      ras_age <= '0;
      cur <= '0;
      pins <= PINS_IDLE;
    end else if (ce) begin
      state <= next_state;
      tmr <= next_tmr;
      ras_age <= next_ras_age;
      cur <= next_cur;
      pins <= next_pins;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rsp_valid <= 1'h0;
      rsp_data <= '0;
    end else if (ce) begin
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  a_ras_min_low: assert property (@(posedge mclk) disable iff (reset)
    $fell(pins.ras_n) |-> !pins.ras_n [*3])
    else $error("row strobe low shorter than minimum");

  a_ras_precharge: assert property (@(posedge mclk) disable iff (reset)
    $rose(pins.ras_n) |-> pins.ras_n [*3])
    else $error("row strobe precharge too short");

  a_read_we_high: assert property (@(posedge mclk) disable iff (reset)
    (!pins.cas_n && !pins.transfer_or_output_enable_n) |-> pins.mask_select_write_enable_n)
    else $error("write-enable low during a read");

  a_oe_no_drive: assert property (@(posedge mclk) disable iff (reset)
    !pins.transfer_or_output_enable_n |-> !pins.mask_or_data_pins_oe)
    else $error("host drives data while device output is enabled");

  a_write_data_valid: assert property (@(posedge mclk) disable iff (reset)
    ($fell(pins.cas_n) && !pins.mask_select_write_enable_n) |->
      (pins.mask_or_data_pins_oe && pins.mask_or_data_pins_out == cur.wdata))
    else $error("write data not valid at column strobe fall");

  a_flash_levels: assert property (@(posedge mclk) disable iff (reset)
    ($fell(pins.ras_n) && pins.special_function_select) |->
      (pins.cas_n && !pins.mask_select_write_enable_n && pins.mask_or_data_pins_oe)
      ##1 pins.cas_n)
    else $error("flash write levels wrong at row strobe fall");

  a_block_col_bits: assert property (@(posedge mclk) disable iff (reset)
    ($fell(pins.cas_n) && !pins.ras_n && pins.special_function_select) |->
      (pins.addr[1:0] == 2'h0 && !pins.mask_select_write_enable_n))
    else $error("block write column levels wrong");

  a_oe_high_ras_fall: assert property (@(posedge mclk) disable iff (reset)
    ($fell(pins.ras_n) && pins.cas_n) |-> pins.transfer_or_output_enable_n)
    else $error("output-enable low at row strobe fall");

  a_hidden_cas_held: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_HIDDEN && ce) |-> (!pins.cas_n && !pins.transfer_or_output_enable_n
      && pins.ras_n) ##1 !pins.cas_n)
    else $error("column strobe released during hidden refresh");

endmodule

// file: verilog/vdrp_pkg.sv
package vdrp_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 40;

  // Pin widths, row count and block column bits
  localparam int ADDR_W = 9;
  localparam int DQ_W = 4;
  localparam int ROWS = 512;
  localparam int BLOCK_COL_LSB = 2;

  // Strobe timing, in ns (plain defaults; set to the speed grade in use)
  localparam int T_RAS_NS = 100;
  localparam int T_RCD_NS = 40;
  localparam int T_CAS_NS = 30;
  localparam int T_CAC_NS = 30;
  localparam int T_RP_NS = 90;
  localparam int T_CP_NS = 15;
  localparam int T_CSR_NS = 10;
  localparam int T_REFRESH_NS = 8000000;

  function automatic int cyc_up(int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RAS_CYC = cyc_up(T_RAS_NS);
  localparam int RCD_CYC = cyc_up(T_RCD_NS);
  localparam int COL_CYC = cyc_up((T_CAS_NS > T_CAC_NS) ? T_CAS_NS : T_CAC_NS);
  localparam int RP_CYC = cyc_up(T_RP_NS);
  localparam int CP_CYC = cyc_up(T_CP_NS);
  localparam int CSR_CYC = cyc_up(T_CSR_NS);
  // Longest spacing between two refreshes rounds down
  localparam int REF_INT_CYC = T_REFRESH_NS / ROWS / CLK_PERIOD_NS;

  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] TMR_RAS = TMR_W'(RAS_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_RCD = TMR_W'(RCD_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_COL = TMR_W'(COL_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_RP = TMR_W'(RP_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_CP = TMR_W'(CP_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_CSR = TMR_W'(CSR_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_MAX = 4'hf;

  localparam int REF_CNT_W = 9;
  localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_INT_CYC - 1);

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_BLOCK = 3'h2,
    OP_FLASH = 3'h3,
    OP_REF_ROW = 3'h4,
    OP_REF_CBR = 3'h5
  } vdrp_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_COL = 3'h3,
    ST_PAGE = 3'h2,
    ST_PRE = 3'h6,
    ST_CBR_CAS = 3'h7,
    ST_CBR_RAS = 3'h5,
    ST_HIDDEN = 3'h4
  } vdrp_state_e;

  typedef struct packed {
    vdrp_op_e op;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] mask;
    logic use_mask;
    logic keep_page;
  } vdrp_req_s;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic mask_select_write_enable_n;
    logic transfer_or_output_enable_n;
    logic special_function_select;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] mask_or_data_pins_out;
    logic mask_or_data_pins_oe;
  } vdrp_pins_s;

  localparam vdrp_pins_s PINS_IDLE = '{
    ras_n: 1'h1, cas_n: 1'h1, mask_select_write_enable_n: 1'h1,
    transfer_or_output_enable_n: 1'h1, special_function_select: 1'h0,
    addr: 9'h000, mask_or_data_pins_out: 4'h0, mask_or_data_pins_oe: 1'h0};

endpackage

// file: verilog/vdrp_refresh_timer.sv
`timescale 1ns/1ps
module vdrp_refresh_timer
  import vdrp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Refresh handshake
  input wire logic ack,
  output logic due
);

  logic [REF_CNT_W-1:0] cnt;
  logic [REF_CNT_W-1:0] next_cnt;
  logic next_due;
  logic tick;

  always_comb begin
    tick = (cnt == REF_LAST);
    next_cnt = tick ? '0 : cnt + 1'h1;
    // A tick in the same cycle as the ack keeps the request alive
    next_due = tick | (due & ~ack);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt <= '0;
      due <= 1'h0;
    end else if (ce) begin
      cnt <= next_cnt;
      due <= next_due;
    end
  end

endmodule

// file: tb/vdrp_mem_model.sv
`timescale 1ns/1ps
module vdrp_mem_model
  import vdrp_pkg::*;
#(
  parameter logic [DQ_W-1:0] COLOR = 4'ha
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins from the controller
  input wire vdrp_pins_s pins,
  input wire logic [DQ_W-1:0] dq,
  // Device side of the data pins
  output logic [DQ_W-1:0] dev_q,
  output logic dev_oe,
  // Observation
  output logic [15:0] cbr_count,
  output logic [ADDR_W-1:0] ref_row,
  output logic viol
);
  logic [DQ_W-1:0] mem [logic [17:0]];
  logic s_ras, s_cas, blk_sel;
  logic [ADDR_W-1:0] row_l, col_l, ref_cnt, col_now;
  logic [DQ_W-1:0] mask_l;
  int lo, hi;

  function automatic void put(logic [17:0] a, logic [DQ_W-1:0] d);
    logic [DQ_W-1:0] old;
    old = mem.exists(a) ? mem[a] : 4'h0;
    mem[a] = (old & ~mask_l) | (d & mask_l);
  endfunction

  // Column follows the pins in the cycle the column strobe falls, so data is ready in time
  assign col_now = s_cas ? pins.addr : col_l;
  assign dev_q = mem.exists({row_l, col_now}) ? mem[{row_l, col_now}] : 4'h0;
  assign dev_oe = !pins.cas_n && !pins.transfer_or_output_enable_n
    && pins.mask_select_write_enable_n;

  // Strobe edges are seen one clock late, on values that have settled
  always @(posedge mclk) begin
    if (reset) begin
      s_ras = 1'b1;
      s_cas = 1'b1;
      hi = 99;
      lo = 0;
      ref_cnt = '0;
      row_l = '0;
      col_l = '0;
      mask_l = 4'hf;
      blk_sel = 1'b0;
      ref_row = '0;
      cbr_count = '0;
      viol = 1'b0;
    end else begin
      if (s_ras && !pins.ras_n) begin
        if (hi < RP_CYC) viol = 1'b1;
        if (pins.cas_n) begin
          row_l = pins.addr;
          ref_row = pins.addr;
          mask_l = pins.mask_select_write_enable_n ? 4'hf : dq;
          blk_sel = !pins.special_function_select && pins.transfer_or_output_enable_n;
          if (!pins.mask_select_write_enable_n && pins.special_function_select) begin
            for (int c = 0; c < (1 << ADDR_W); c++) put({row_l, 9'(c)}, 4'h0);
          end
        end else begin
          ref_row = ref_cnt;
          ref_cnt = ref_cnt + 1'b1;
          cbr_count = cbr_count + 1'b1;
        end
      end
      if (s_cas && !pins.cas_n && !pins.ras_n) begin
        col_l = pins.addr;
        if (blk_sel && pins.special_function_select) begin
          for (int i = 0; i < 4; i++) begin
            if (dq[i]) put({row_l, pins.addr[8:2], 2'(i)}, COLOR);
          end
        end else if (!pins.mask_select_write_enable_n) begin
          put({row_l, pins.addr}, dq);
        end
      end
      if (!s_ras && pins.ras_n && lo < RAS_CYC) viol = 1'b1;
      lo = pins.ras_n ? 0 : lo + 1;
      hi = pins.ras_n ? hi + 1 : 0;
      s_ras = pins.ras_n;
      s_cas = pins.cas_n;
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top
  import vdrp_pkg::*;
;
  localparam logic [3:0] COLOR_V = 4'ha;
  logic mclk, reset, req_valid, req_ready, rsp_valid, refresh_pending, dev_oe, viol;
  vdrp_req_s req;
  vdrp_pins_s pins;
  logic [3:0] rsp_data, dq, dq_last, dev_q;
  logic [15:0] cbr_count, n;
  logic [8:0] ref_row;
  int fails, total_checks;

  initial begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  vdrp_ctrl DUT (.mclk(mclk), .reset(reset), .ce(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .refresh_pending(refresh_pending), .pins(pins), .mask_or_data_pins_in(dq));
  vdrp_mem_model #(.COLOR(COLOR_V)) mem_i (.mclk(mclk), .reset(reset), .pins(pins),
    .dq(dq), .dev_q(dev_q), .dev_oe(dev_oe), .cbr_count(cbr_count), .ref_row(ref_row),
    .viol(viol));

  // Undriven bus shows the inverse of its last level, so stale data cannot pass
  assign dq = pins.mask_or_data_pins_oe ? pins.mask_or_data_pins_out : dev_oe ? dev_q : ~dq_last;
  always @(posedge mclk) dq_last <= dq;

  task automatic issue(vdrp_op_e op, logic [8:0] row, logic [8:0] col, logic [3:0] wd,
    logic [3:0] mk, logic um, logic kp);
    logic ok;
    ok = 1'b0;
    @(posedge mclk);
    req <= '{op, row, col, wd, mk, um, kp};
    req_valid <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge mclk);
      if (req_ready === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    `CHK(ok, 1'b1)
  endtask

  task automatic rd_chk(logic [8:0] row, logic [8:0] col, logic kp, logic [3:0] exp);
    logic [3:0] d;
    d = 'x;
    issue(OP_READ, row, col, 4'h0, 4'h0, 1'b0, kp);
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) begin
        d = rsp_data;
        break;
      end
    end
    `CHK(d, exp)
  endtask

  task automatic t_basic_mask();
    issue(OP_WRITE, 9'h003, 9'h007, 4'h5, 4'h0, 1'b0, 1'b0);
    issue(OP_WRITE, 9'h1ff, 9'h1ff, 4'ha, 4'h0, 1'b0, 1'b0);
    rd_chk(9'h003, 9'h007, 1'b0, 4'h5);
    rd_chk(9'h1ff, 9'h1ff, 1'b0, 4'ha);
    issue(OP_WRITE, 9'h010, 9'h020, 4'hf, 4'h0, 1'b0, 1'b0);
    issue(OP_WRITE, 9'h010, 9'h020, 4'h0, 4'h3, 1'b1, 1'b0);
    rd_chk(9'h010, 9'h020, 1'b0, 4'hc);
    issue(OP_WRITE, 9'h010, 9'h020, 4'h6, 4'h0, 1'b0, 1'b0);
    rd_chk(9'h010, 9'h020, 1'b0, 4'h6);
  endtask

  task automatic t_page();
    issue(OP_WRITE, 9'h044, 9'h001, 4'h1, 4'h0, 1'b0, 1'b1);
    issue(OP_WRITE, 9'h044, 9'h002, 4'h2, 4'h0, 1'b0, 1'b1);
    rd_chk(9'h044, 9'h001, 1'b1, 4'h1);
    issue(OP_WRITE, 9'h044, 9'h003, 4'h3, 4'h0, 1'b0, 1'b1);
    rd_chk(9'h044, 9'h002, 1'b1, 4'h2);
    rd_chk(9'h044, 9'h003, 1'b0, 4'h3);
  endtask

  task automatic t_block_flash();
    for (int i = 8; i < 12; i++) issue(OP_WRITE, 9'h005, 9'(i), 4'h1, 4'h0, 1'b0, 1'b0);
    // Low column bits set on purpose: the block must still start at column 8
    issue(OP_BLOCK, 9'h005, 9'h00b, 4'h5, 4'h0, 1'b0, 1'b0);
    for (int i = 8; i < 12; i++) rd_chk(9'h005, 9'(i), 1'b0, (i % 2) ? 4'h1 : COLOR_V);
    issue(OP_WRITE, 9'h006, 9'h002, 4'hf, 4'h0, 1'b0, 1'b0);
    issue(OP_WRITE, 9'h006, 9'h1f0, 4'h9, 4'h0, 1'b0, 1'b0);
    issue(OP_FLASH, 9'h006, 9'h000, 4'h0, 4'h3, 1'b1, 1'b0);
    rd_chk(9'h006, 9'h002, 1'b0, 4'hc);
    rd_chk(9'h006, 9'h1f0, 1'b0, 4'h8);
  endtask

  task automatic t_refresh();
    n = cbr_count;
    issue(OP_REF_CBR, 9'h000, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 20 && cbr_count === n; i++) @(negedge mclk);
    `CHK(cbr_count, n + 16'h1)
    issue(OP_REF_ROW, 9'h0a5, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 20 && ref_row !== 9'h0a5; i++) @(negedge mclk);
    `CHK(ref_row, 9'h0a5)
    n = cbr_count;
    for (int i = 0; i < 100 && cbr_count === n; i++) rd_chk(9'h003, 9'h007, 1'b0, 4'h5);
    `CHK(cbr_count, n + 16'h1)
  endtask

  task automatic t_hidden();
    // Line the read up so the next timer tick falls due in its column phase
    while (refresh_pending === 1'b1) @(negedge mclk);
    while (refresh_pending !== 1'b1) @(negedge mclk);
    n = cbr_count;
    repeat (REF_INT_CYC - 3) @(posedge mclk);
    rd_chk(9'h003, 9'h007, 1'b0, 4'h5);
    `CHK({pins.ras_n, pins.cas_n, dq}, {1'b1, 1'b0, 4'h5})
    `CHK(refresh_pending, 1'b0)
    repeat (8) @(negedge mclk);
    `CHK(cbr_count, n + 16'h2)
  endtask

  task automatic results();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 20000);
    fails++;
    results();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_basic_mask();
    t_page();
    t_block_flash();
    t_refresh();
    t_hidden();
    `CHK(viol, 1'b0)
    results();
  end
endmodule
